//--- fgc_pkg.sv
// Constants shared by the fault, pin three and time-base register slice
package fgc_pkg;

  // **********************************************************************
  // Register offsets
  // **********************************************************************
  localparam logic [7:0] FGC_OFS_FAULT_TWO   = 8'h41;
  localparam logic [7:0] FGC_OFS_PIN3_CTRL   = 8'h42;
  localparam logic [7:0] FGC_OFS_DIVIDER     = 8'h43;

  // **********************************************************************
  // Field positions
  // **********************************************************************
  localparam int FGC_F2_RESERVED    = 7;
  localparam int FGC_F2_PIN_ONE     = 6;
  localparam int FGC_F2_PIN_TWO     = 5;
  localparam int FGC_F2_PIN_THREE   = 4;
  localparam int FGC_F2_STUCK_WAKE  = 3;
  localparam int FGC_F2_ENERGY_OVF  = 2;
  localparam int FGC_F2_CHARGE_OVF  = 1;
  localparam int FGC_F2_TIME_OVF    = 0;
  localparam int FGC_GC_ALERT_GEN   = 7;
  localparam int FGC_GC_PULL_DOWN   = 6;
  localparam int FGC_DIV_WIDTH      = 5;

  // **********************************************************************
  // Reset values
  // **********************************************************************
  localparam logic [7:0] FGC_RST_FAULT_TWO   = 8'h80;
  localparam logic [1:0] FGC_RST_PIN3_CTRL   = 2'h0;
  localparam logic [4:0] FGC_RST_DIVIDER     = 5'h04;

  // **********************************************************************
  // Pin configuration codes
  // **********************************************************************
  localparam logic [1:0] FGC_CFG_IN_HIGH     = 2'h3;
  localparam logic [1:0] FGC_CFG_IN_LOW      = 2'h2;
  localparam logic [1:0] FGC_CFG_GP_OUT      = 2'h1;
  localparam logic [1:0] FGC_CFG_ALERT_OUT   = 2'h0;

  // **********************************************************************
  // Identity value, arbitrary
  // **********************************************************************
  localparam logic [15:0] FGC_MAKER_PART_CODE = 16'h5A5A;

endpackage

//--- fgc_regs.sv
// Fault flags, pin three control, time-base divider and data byte layout
`timescale 1ns/1ns
`default_nettype none

module fgc_regs
  import fgc_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic        REG_WRITE,
  input  wire logic        REG_READ,
  input  wire logic [7:0]  REG_WDATA,
  output logic      [7:0]  REG_RDATA,
  input  wire logic [1:0]  PIN_ONE_CONFIG,
  input  wire logic [1:0]  PIN_TWO_CONFIG,
  input  wire logic [1:0]  PIN_THREE_CONFIG,
  input  wire logic        GP_PIN_ONE_IN,
  input  wire logic        GP_PIN_TWO_IN,
  input  wire logic        GP_PIN_THREE_IN,
  output logic             GP_PIN_THREE_OUT,
  output logic             GP_PIN_THREE_OE_N,
  input  wire logic        STUCK_BUS_TIMEOUT_ENABLE,
  input  wire logic        STUCK_BUS_WAKE,
  input  wire logic        ENERGY_OVERFLOW,
  input  wire logic        CHARGE_OVERFLOW,
  input  wire logic        TIME_OVERFLOW,
  input  wire logic        ALERT_EVENT,
  input  wire logic        EXT_TIMEBASE_INPUT,
  output logic             SYS_CLOCK_OUT,
  input  wire logic [11:0] ADC_VALUE,
  input  wire logic [23:0] POWER_VALUE,
  input  wire logic [31:0] ACC_VALUE,
  output logic      [7:0]  ADC_VALUE_HIGH_BYTE,
  output logic      [7:0]  ADC_VALUE_LOW_BYTE,
  output logic      [7:0]  POWER_VALUE_BYTE2,
  output logic      [7:0]  POWER_VALUE_BYTE1,
  output logic      [7:0]  POWER_VALUE_BYTE0,
  output logic      [7:0]  ACCUMULATOR_BYTE3,
  output logic      [7:0]  ACCUMULATOR_BYTE2,
  output logic      [7:0]  ACCUMULATOR_BYTE1,
  output logic      [7:0]  ACCUMULATOR_BYTE0,
  output logic      [7:0]  MAKER_PART_CODE_HIGH,
  output logic      [7:0]  MAKER_PART_CODE_LOW
);

  // **********************************************************************
  // Pin synchronisers
  // **********************************************************************
  logic [3:0] sync_first;
  logic [3:0] sync_second;
  logic [2:0] pin_level;
  logic       timebase_level;

  // First stage feeds only the second stage; pins are asynchronous
  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      sync_first  <= 4'h0;
      sync_second <= 4'h0;
    end
    else
    begin
      sync_first  <= {EXT_TIMEBASE_INPUT, GP_PIN_THREE_IN, GP_PIN_TWO_IN, GP_PIN_ONE_IN};
      sync_second <= sync_first;
    end
  end

  assign pin_level      = sync_second[2:0];
  assign timebase_level = sync_second[3];

  // **********************************************************************
  // Register access decode
  // **********************************************************************
  logic wr_fault;
  logic wr_pin3;
  logic wr_div;

  assign wr_fault = REG_WRITE && (REG_ADDR == FGC_OFS_FAULT_TWO);
  assign wr_pin3  = REG_WRITE && (REG_ADDR == FGC_OFS_PIN3_CTRL);
  assign wr_div   = REG_WRITE && (REG_ADDR == FGC_OFS_DIVIDER);

  // **********************************************************************
  // Fault flag sources
  // **********************************************************************
  logic [1:0] pin_config [3];
  logic [7:0] fault_set;

  assign pin_config[0] = PIN_ONE_CONFIG;
  assign pin_config[1] = PIN_TWO_CONFIG;
  assign pin_config[2] = PIN_THREE_CONFIG;

  // Pin one maps to bit 6, pin three to bit 4
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_pin_fault
      assign fault_set[FGC_F2_PIN_ONE - g] =
        ((pin_config[g] == FGC_CFG_IN_HIGH) &&  pin_level[g]) ||
        ((pin_config[g] == FGC_CFG_IN_LOW)  && !pin_level[g]);
    end
  endgenerate

  assign fault_set[FGC_F2_RESERVED]   = 1'b0;
  assign fault_set[FGC_F2_STUCK_WAKE] = STUCK_BUS_TIMEOUT_ENABLE && STUCK_BUS_WAKE;
  assign fault_set[FGC_F2_ENERGY_OVF] = ENERGY_OVERFLOW;
  assign fault_set[FGC_F2_CHARGE_OVF] = CHARGE_OVERFLOW;
  assign fault_set[FGC_F2_TIME_OVF]   = TIME_OVERFLOW;

  // **********************************************************************
  // Sticky fault flags
  // **********************************************************************
  logic [7:0] fault_two;
  logic [7:0] next_fault_two;

  // A new event still lands beside a clearing write, so no fault is lost
  always_comb
  begin
    next_fault_two = fault_two;
    if (wr_fault)
    begin
      next_fault_two = fault_two & REG_WDATA;
    end
    next_fault_two = next_fault_two | fault_set;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      fault_two <= FGC_RST_FAULT_TWO;
    end
    else
    begin
      fault_two <= next_fault_two;
    end
  end

  // **********************************************************************
  // Pin three control
  // **********************************************************************
  logic alert_generated;
  logic pull_down;

  // Only a written zero clears it; an alert in the clearing cycle wins
  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      alert_generated <= FGC_RST_PIN3_CTRL[1];
    end
    else if (ALERT_EVENT)
    begin
      alert_generated <= 1'b1;
    end
    else if (wr_pin3)
    begin
      alert_generated <= REG_WDATA[FGC_GC_ALERT_GEN];
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      pull_down <= FGC_RST_PIN3_CTRL[0];
    end
    else if (wr_pin3)
    begin
      pull_down <= REG_WDATA[FGC_GC_PULL_DOWN];
    end
  end

  // **********************************************************************
  // Pin three driver
  // **********************************************************************
  logic pin3_drive_low;

  // The pin only ever pulls low; high is left to the external pull-up
  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      pin3_drive_low <= 1'b0;
    end
    else
    begin
      unique case (PIN_THREE_CONFIG)
        FGC_CFG_ALERT_OUT: pin3_drive_low <= alert_generated;
        FGC_CFG_GP_OUT:    pin3_drive_low <= pull_down;
        FGC_CFG_IN_LOW, FGC_CFG_IN_HIGH: pin3_drive_low <= 1'b0;
      endcase
    end
  end

  assign GP_PIN_THREE_OUT  = 1'b0;
  assign GP_PIN_THREE_OE_N = !pin3_drive_low;

  // **********************************************************************
  // Time-base divider
  // **********************************************************************
  logic [4:0] divider;
  logic       timebase_prev;
  logic       timebase_rise;
  logic [5:0] edge_count;
  logic [5:0] half_period;
  logic       sys_clock;

  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      divider <= FGC_RST_DIVIDER;
    end
    else if (wr_div)
    begin
      divider <= REG_WDATA[FGC_DIV_WIDTH-1:0];
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      timebase_prev <= 1'b0;
    end
    else
    begin
      timebase_prev <= timebase_level;
    end
  end

  assign timebase_rise = timebase_level && !timebase_prev;

  // Toggle every 2*N rises: period of 4*N input cycles; a zero divider wraps, never stalls
  assign half_period = 6'({divider, 1'b0} - 6'h01);

  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      edge_count <= 6'h00;
      sys_clock  <= 1'b0;
    end
    else if (timebase_rise)
    begin
      if (edge_count >= half_period)
      begin
        edge_count <= 6'h00;
        sys_clock  <= !sys_clock;
      end
      else
      begin
        edge_count <= 6'(edge_count + 6'h01);
      end
    end
  end

  assign SYS_CLOCK_OUT = sys_clock;

  // **********************************************************************
  // Register read port
  // **********************************************************************
  logic [7:0] next_rdata;

  always_comb
  begin
    unique case (REG_ADDR)
      FGC_OFS_FAULT_TWO: next_rdata = fault_two;
      FGC_OFS_PIN3_CTRL: next_rdata = {alert_generated, pull_down, 6'h00};
      FGC_OFS_DIVIDER:   next_rdata = {3'h0, divider};
      default:           next_rdata = 8'h00;
    endcase
  end

  // Data is held until the next read so the slave engine may shift it
  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      REG_RDATA <= 8'h00;
    end
    else if (REG_READ)
    begin
      REG_RDATA <= next_rdata;
    end
  end

  // **********************************************************************
  // Measurement byte layout
  // **********************************************************************
  logic [7:0] acc_bytes [4];
  logic [7:0] pwr_bytes [3];

  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      ADC_VALUE_HIGH_BYTE <= 8'h00;
      ADC_VALUE_LOW_BYTE  <= 8'h00;
    end
    else
    begin
      ADC_VALUE_HIGH_BYTE <= ADC_VALUE[11:4];
      ADC_VALUE_LOW_BYTE  <= {ADC_VALUE[3:0], 4'h0};
    end
  end

  // Byte index 0 holds the least significant bits, read out last
  generate
    for (g = 0; g < 3; g++)
    begin : g_power_byte
      always_ff @(posedge CLOCK)
      begin
        if (!RESETN)
        begin
          pwr_bytes[g] <= 8'h00;
        end
        else
        begin
          pwr_bytes[g] <= POWER_VALUE[8*g +: 8];
        end
      end
    end
    for (g = 0; g < 4; g++)
    begin : g_acc_byte
      always_ff @(posedge CLOCK)
      begin
        if (!RESETN)
        begin
          acc_bytes[g] <= 8'h00;
        end
        else
        begin
          acc_bytes[g] <= ACC_VALUE[8*g +: 8];
        end
      end
    end
  endgenerate

  assign POWER_VALUE_BYTE2 = pwr_bytes[2];
  assign POWER_VALUE_BYTE1 = pwr_bytes[1];
  assign POWER_VALUE_BYTE0 = pwr_bytes[0];
  assign ACCUMULATOR_BYTE3 = acc_bytes[3];
  assign ACCUMULATOR_BYTE2 = acc_bytes[2];
  assign ACCUMULATOR_BYTE1 = acc_bytes[1];
  assign ACCUMULATOR_BYTE0 = acc_bytes[0];

  // Identity value is arbitrary and carries no maker meaning
  assign MAKER_PART_CODE_HIGH = FGC_MAKER_PART_CODE[15:8];
  assign MAKER_PART_CODE_LOW  = FGC_MAKER_PART_CODE[7:0];

endmodule

`default_nettype wire

//--- fgc_regs_sva.sv
// Port-level assertions for the fault, pin three and divider register slice
`timescale 1ns/1ns
`default_nettype none

module fgc_regs_sva
  import fgc_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        RESETN,
  input wire logic [7:0]  REG_ADDR,
  input wire logic        REG_WRITE,
  input wire logic        REG_READ,
  input wire logic [7:0]  REG_RDATA,
  input wire logic [1:0]  PIN_THREE_CONFIG,
  input wire logic        GP_PIN_THREE_OUT,
  input wire logic        GP_PIN_THREE_OE_N,
  input wire logic        ENERGY_OVERFLOW,
  input wire logic        ALERT_EVENT,
  input wire logic [11:0] ADC_VALUE,
  input wire logic [23:0] POWER_VALUE,
  input wire logic [31:0] ACC_VALUE,
  input wire logic [7:0]  ADC_VALUE_HIGH_BYTE,
  input wire logic [7:0]  ADC_VALUE_LOW_BYTE,
  input wire logic [7:0]  POWER_VALUE_BYTE2,
  input wire logic [7:0]  POWER_VALUE_BYTE1,
  input wire logic [7:0]  POWER_VALUE_BYTE0,
  input wire logic [7:0]  ACCUMULATOR_BYTE3,
  input wire logic [7:0]  ACCUMULATOR_BYTE2,
  input wire logic [7:0]  ACCUMULATOR_BYTE1,
  input wire logic [7:0]  ACCUMULATOR_BYTE0
);
  // ********************************
  // Properties
  // ********************************
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);

  AST_OUT_LOW: assert property (GP_PIN_THREE_OUT == 1'b0)
    else $error("pin three data not low");
  AST_ALERT_PULLS: assert property (ALERT_EVENT &&
    PIN_THREE_CONFIG == FGC_CFG_ALERT_OUT ##1 PIN_THREE_CONFIG == FGC_CFG_ALERT_OUT
    |=> !GP_PIN_THREE_OE_N)
    else $error("alert did not pull pin three low");
  AST_INPUT_RELEASE: assert property (PIN_THREE_CONFIG[1] |=> GP_PIN_THREE_OE_N)
    else $error("pin three driven while an input");
  AST_PIN3_RSVD: assert property (REG_READ && REG_ADDR == FGC_OFS_PIN3_CTRL
    |=> REG_RDATA[5:0] == 6'h00)
    else $error("pin three control low bits not zero");
  AST_DIV_RSVD: assert property (REG_READ && REG_ADDR == FGC_OFS_DIVIDER
    |=> REG_RDATA[7:5] == 3'h0)
    else $error("divider upper bits not zero");
  // A clearing write between event and read would legally drop the flag
  AST_OVF_FLAG: assert property (ENERGY_OVERFLOW ##1
    !(REG_WRITE && REG_ADDR == FGC_OFS_FAULT_TWO) ##1
    (REG_READ && REG_ADDR == FGC_OFS_FAULT_TWO) |=> REG_RDATA[FGC_F2_ENERGY_OVF])
    else $error("energy overflow flag missing");
  AST_ADC_BYTES: assert property ($past(RESETN) |->
    {ADC_VALUE_HIGH_BYTE, ADC_VALUE_LOW_BYTE} == {$past(ADC_VALUE), 4'h0})
    else $error("adc byte layout wrong");
  AST_POWER_BYTES: assert property ($past(RESETN) |->
    {POWER_VALUE_BYTE2, POWER_VALUE_BYTE1, POWER_VALUE_BYTE0} == $past(POWER_VALUE))
    else $error("power byte layout wrong");
  AST_ACC_BYTES: assert property ($past(RESETN) |-> {ACCUMULATOR_BYTE3,
    ACCUMULATOR_BYTE2, ACCUMULATOR_BYTE1, ACCUMULATOR_BYTE0} == $past(ACC_VALUE))
    else $error("accumulator byte layout wrong");
endmodule

bind fgc_regs fgc_regs_sva i_sva (.CLOCK, .RESETN, .REG_ADDR, .REG_WRITE, .REG_READ, .REG_RDATA,
  .PIN_THREE_CONFIG, .GP_PIN_THREE_OUT, .GP_PIN_THREE_OE_N, .ENERGY_OVERFLOW, .ALERT_EVENT,
  .ADC_VALUE, .POWER_VALUE, .ACC_VALUE, .ADC_VALUE_HIGH_BYTE, .ADC_VALUE_LOW_BYTE,
  .POWER_VALUE_BYTE2, .POWER_VALUE_BYTE1, .POWER_VALUE_BYTE0, .ACCUMULATOR_BYTE3,
  .ACCUMULATOR_BYTE2, .ACCUMULATOR_BYTE1, .ACCUMULATOR_BYTE0);
`default_nettype wire

//--- fgc_host.sv
// Host model issuing single-byte register reads and writes
`timescale 1ns/1ns
`default_nettype none

module fgc_host
(
  input  wire logic       clock,
  input  wire logic [7:0] reg_rdata,
  output var logic  [7:0] reg_addr,
  output var logic        reg_write,
  output var logic        reg_read,
  output var logic  [7:0] reg_wdata
);
  // ********************************
  // Bus cycles
  // ********************************
  initial
  begin
    reg_addr  = 8'h00;
    reg_write = 1'b0;
    reg_read  = 1'b0;
    reg_wdata = 8'h00;
  end

  // Idle data is inverted so the design cannot lean on a stale byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr  = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    d        = reg_rdata;
  endtask
endmodule
`default_nettype wire

//--- fgc_regs_bench.sv
// Self-checking bench for the fault, pin three and divider register slice
`timescale 1ns/1ns
`default_nettype none

module fgc_regs_bench;
  import fgc_pkg::*;
  // ********************************
  // Stimulus and observation
  // ********************************
  logic        clk = 1'b0;
  logic        sq  = 1'b0;
  logic        rstn, rw, rr, en, wake, eo, co, to, alrt, tb, po, oen, sys;
  logic [7:0]  ra, wd, rdat, v;
  logic [7:0]  b [0:10];
  logic [1:0]  c1, c2, c3;
  logic [2:0]  gp;
  logic [11:0] adc;
  logic [23:0] pw;
  logic [31:0] acc;
  int          errors, samples_checked, cyc, toggles;

  fgc_regs i_dut (.CLOCK(clk), .RESETN(rstn), .REG_ADDR(ra), .REG_WRITE(rw), .REG_READ(rr),
    .REG_WDATA(wd), .REG_RDATA(rdat), .PIN_ONE_CONFIG(c1), .PIN_TWO_CONFIG(c2),
    .PIN_THREE_CONFIG(c3), .GP_PIN_ONE_IN(gp[0]), .GP_PIN_TWO_IN(gp[1]),
    .GP_PIN_THREE_IN(gp[2]), .GP_PIN_THREE_OUT(po), .GP_PIN_THREE_OE_N(oen),
    .STUCK_BUS_TIMEOUT_ENABLE(en), .STUCK_BUS_WAKE(wake), .ENERGY_OVERFLOW(eo),
    .CHARGE_OVERFLOW(co), .TIME_OVERFLOW(to), .ALERT_EVENT(alrt), .EXT_TIMEBASE_INPUT(tb),
    .SYS_CLOCK_OUT(sys), .ADC_VALUE(adc), .POWER_VALUE(pw), .ACC_VALUE(acc),
    .ADC_VALUE_HIGH_BYTE(b[0]), .ADC_VALUE_LOW_BYTE(b[1]), .POWER_VALUE_BYTE2(b[2]),
    .POWER_VALUE_BYTE1(b[3]), .POWER_VALUE_BYTE0(b[4]), .ACCUMULATOR_BYTE3(b[5]),
    .ACCUMULATOR_BYTE2(b[6]), .ACCUMULATOR_BYTE1(b[7]), .ACCUMULATOR_BYTE0(b[8]),
    .MAKER_PART_CODE_HIGH(b[9]), .MAKER_PART_CODE_LOW(b[10]));

  fgc_host i_host (.clock(clk), .reg_rdata(rdat), .reg_addr(ra), .reg_write(rw),
    .reg_read(rr), .reg_wdata(wd));

  always #50 clk = ~clk;

  // Runs are under 500 cycles; the 5000-cycle ceiling only catches a hang
  always @(posedge clk)
  begin
    cyc++;
    if (sys !== sq)
      toggles++;
    sq = sys;
    if (cyc == 5000)
    begin
      errors++;
      results;
    end
  end

  // ********************************
  // Checking helpers
  // ********************************
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, v);
    chk($sformatf("register %h", a), e, v);
  endtask

  task automatic results;
    if (errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ********************************
  // Scenarios
  // ********************************
  task automatic t_reset;
    rchk(FGC_OFS_FAULT_TWO, FGC_RST_FAULT_TWO);
    rchk(FGC_OFS_PIN3_CTRL, {FGC_RST_PIN3_CTRL, 6'h00});
    rchk(FGC_OFS_DIVIDER, {3'h0, FGC_RST_DIVIDER});
    rchk(8'h44, 8'h00);
  endtask

  task automatic t_faults;
    logic [7:0] e;
    i_host.wr(FGC_OFS_FAULT_TWO, 8'hFF);
    rchk(FGC_OFS_FAULT_TWO, 8'h80);
    i_host.wr(FGC_OFS_FAULT_TWO, 8'h00);
    rchk(FGC_OFS_FAULT_TWO, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      e = (i < 4) ? 8'h01 << i : 8'h00;
      @(negedge clk);
      {en, wake, eo, co, to} = {i != 4, i >= 3, i == 2, i == 1, i == 0};
      @(negedge clk);
      {wake, eo, co, to} = 4'h0;
      rchk(FGC_OFS_FAULT_TWO, e);
      rchk(FGC_OFS_FAULT_TWO, e);
      i_host.wr(FGC_OFS_FAULT_TWO, 8'h00);
    end
    // An overflow in the cycle of a clearing write must survive it
    fork
      i_host.wr(FGC_OFS_FAULT_TWO, 8'h00);
      begin
        @(negedge clk);
        eo = 1'b1;
        @(negedge clk);
        eo = 1'b0;
      end
    join
    rchk(FGC_OFS_FAULT_TWO, 8'h04);
    i_host.wr(FGC_OFS_FAULT_TWO, 8'h00);
  endtask

  task automatic t_pins;
    {c1, c2, c3, gp} = 9'h1F8;
    repeat (4) @(negedge clk);
    i_host.wr(FGC_OFS_FAULT_TWO, 8'h00);
    rchk(FGC_OFS_FAULT_TWO, 8'h00);
    gp = 3'h5;
    repeat (4) @(negedge clk);
    rchk(FGC_OFS_FAULT_TWO, 8'h50);
    {c1, c2, c3} = 6'h2A;
    repeat (4) @(negedge clk);
    i_host.wr(FGC_OFS_FAULT_TWO, 8'h00);
    rchk(FGC_OFS_FAULT_TWO, 8'h20);
    {c1, c2, c3, gp} = 9'h0AA;
    repeat (4) @(negedge clk);
    i_host.wr(FGC_OFS_FAULT_TWO, 8'h00);
    rchk(FGC_OFS_FAULT_TWO, 8'h00);
  endtask

  task automatic t_pin3;
    logic exp_oen;
    c3 = FGC_CFG_ALERT_OUT;
    repeat (2) @(negedge clk);
    chk("oe_n", 8'h01, {7'h0, oen});
    chk("pin_out", 8'h00, {7'h0, po});
    alrt = 1'b1;
    @(negedge clk);
    alrt = 1'b0;
    repeat (2) @(negedge clk);
    chk("oe_n", 8'h00, {7'h0, oen});
    rchk(FGC_OFS_PIN3_CTRL, 8'h80);
    i_host.wr(FGC_OFS_PIN3_CTRL, 8'h00);
    @(negedge clk);
    chk("oe_n", 8'h01, {7'h0, oen});
    // An alert in the cycle of a clearing write leaves the bit set
    fork
      i_host.wr(FGC_OFS_PIN3_CTRL, 8'h00);
      begin
        @(negedge clk);
        alrt = 1'b1;
        @(negedge clk);
        alrt = 1'b0;
      end
    join
    rchk(FGC_OFS_PIN3_CTRL, 8'h80);
    for (int j = 0; j < 2; j++)
    begin
      i_host.wr(FGC_OFS_PIN3_CTRL, j ? 8'h40 : 8'h80);
      for (int k = 0; k < 4; k++)
      begin
        c3 = k[1:0];
        exp_oen = !((k == 0 && j == 0) || (k == 1 && j == 1));
        repeat (2) @(negedge clk);
        chk("oe_n", {7'h0, exp_oen}, {7'h0, oen});
      end
    end
  endtask

  // Reset in mid-run must release the pin and restore every register
  task automatic t_rerun;
    c3 = FGC_CFG_GP_OUT;
    repeat (2) @(negedge clk);
    chk("oe_n", 8'h00, {7'h0, oen});
    rstn = 1'b0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    chk("oe_n", 8'h01, {7'h0, oen});
    t_reset;
  endtask

  task automatic t_div;
    int t0;
    i_host.wr(FGC_OFS_DIVIDER, 8'hFF);
    rchk(FGC_OFS_DIVIDER, 8'h1F);
    for (int d = 2; d > 0; d--)
    begin
      i_host.wr(FGC_OFS_DIVIDER, d[7:0]);
      t0 = toggles;
      repeat (16)
      begin
        tb = 1'b1;
        repeat (5) @(negedge clk);
        tb = 1'b0;
        repeat (5) @(negedge clk);
      end
      chk("toggles", 8'(16 / (2 * d)), 8'(toggles - t0));
    end
  endtask

  task automatic t_bytes;
    {adc, pw, acc} = {12'hA5C, 24'h123456, 32'h89ABCDEF};
    repeat (2) @(negedge clk);
    chk("adc_high", 8'hA5, b[0]);
    chk("adc_low", 8'hC0, b[1]);
    for (int i = 0; i < 3; i++)
      chk("power", pw[23 - 8 * i -: 8], b[2 + i]);
    for (int i = 0; i < 4; i++)
      chk("accumulator", acc[31 - 8 * i -: 8], b[5 + i]);
    chk("maker_high", FGC_MAKER_PART_CODE[15:8], b[9]);
    chk("maker_low", FGC_MAKER_PART_CODE[7:0], b[10]);
  endtask

  initial
  begin
    {rstn, en, wake, eo, co, to, alrt, tb, c1, c2, c3, gp} = '0;
    {adc, pw, acc} = '0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    t_reset;
    t_faults;
    t_pins;
    t_pin3;
    t_rerun;
    t_div;
    t_bytes;
    results;
  end
endmodule
`default_nettype wire
